// *** design/sbctl_defs.svh ***
// Constants for the standby and output link state control block
`ifndef SBCTL_DEFS_SVH
`define SBCTL_DEFS_SVH
`define SB_OFS_CTRL      16'h0018
`define SB_OFS_ID        16'h001a
`define SB_OFS_STOPSEL   16'h0042
`define SB_OFS_CORE      16'h301a
`define SB_BIT_REQ       0
`define SB_BIT_STAT      14
`define SB_BIT_CORE      4
`define SB_BIT_EOF       0
`define SB_BIT_SRST      0
`define SB_ID_LSB        12
`define SB_ENTRY_MIN     16742
`define SB_ENTRY_MAX     17032
`define SB_STBY_MIN      16762
`define SB_WAKE_NS       1000
`define SB_WAKE_CYC      ((`SB_WAKE_NS * 200 + 999) / 1000)
`define SB_LP00          2'h0
`define SB_LP10          2'h2
`define SB_LP11          2'h3
`endif

// *** design/sbctl_pkg.sv ***
// Types for the standby and output link state control block
package sbctl_pkg;
   typedef enum logic [5:0] {
      SB_ST_ULPS  = 6'h01,
      SB_ST_EXIT  = 6'h02,
      SB_ST_STOP  = 6'h04,
      SB_ST_HS    = 6'h08,
      SB_ST_EOFP  = 6'h10,
      SB_ST_IDLE  = 6'h20
   } sbctl_link_e;
   typedef struct packed {
      logic [1:0] clk_lp;
      logic [1:0] dat_lp;
      logic       hs;
      logic       oe;
   } sbctl_lane_s;
   typedef struct packed {
      logic [7:0] data;
      logic       lv;
      logic       fv;
   } sbctl_pix_s;
endpackage : sbctl_pkg

// *** design/sbctl_link.sv ***
// Link side state machine, runs on the link clock
`timescale 1ns/1ps
`include "sbctl_defs.svh"
module sbctl_link
   import sbctl_pkg::*;
(
   input  wire logic        clk_link,
   input  wire logic        rstn,
   input  wire logic        stream_req,
   input  wire logic        pll_ready,
   input  wire logic        frame_start,
   input  wire logic        packet_end,
   input  wire logic        frame_end,
   input  wire logic        eof_mode,
   output sbctl_lane_s      lane,
   output logic             link_idle
);
   logic [1:0]  req_sync_reg;
   logic [1:0]  pll_sync_reg;
   logic [1:0]  eof_sync_reg;
   logic [1:0]  lp_code;
   logic        frame_mode;
   sbctl_link_e state_reg;
   sbctl_link_e state_next;
   logic [7:0]  wake_reg;
   logic        going;
   logic        stop_now;
   assign going    = req_sync_reg[1];
   assign stop_now = ~going;
   // Stop point select comes from the system clock side, so it is synchronised too
   assign frame_mode = eof_sync_reg[1];
   always_ff @(posedge clk_link or negedge rstn)
   begin
      if (!rstn)
      begin
         req_sync_reg <= 2'h0;
         pll_sync_reg <= 2'h0;
         eof_sync_reg <= 2'h0;
      end
      else
      begin
         req_sync_reg <= {req_sync_reg[0], stream_req};
         pll_sync_reg <= {pll_sync_reg[0], pll_ready};
         eof_sync_reg <= {eof_sync_reg[0], eof_mode};
      end
   end
   always_comb
   begin
      state_next = state_reg;
      case (state_reg)
         SB_ST_ULPS: if (going && pll_sync_reg[1]) state_next = SB_ST_EXIT;
         SB_ST_EXIT: if (wake_reg == 8'h00) state_next = SB_ST_STOP;
         SB_ST_STOP:
         begin
            if (stop_now) state_next = SB_ST_ULPS;
            else if (frame_start) state_next = SB_ST_HS;
         end
         SB_ST_HS:
         begin
            if (frame_end) state_next = stop_now ? SB_ST_ULPS : SB_ST_STOP;
            else if (stop_now && !frame_mode && packet_end) state_next = SB_ST_EOFP;
            else if (packet_end) state_next = SB_ST_IDLE;
         end
         SB_ST_IDLE:
         begin
            if (stop_now && !frame_mode) state_next = SB_ST_EOFP;
            else state_next = SB_ST_HS;
         end
         SB_ST_EOFP: state_next = SB_ST_ULPS;
         default: state_next = SB_ST_ULPS;
      endcase
   end
   always_ff @(posedge clk_link or negedge rstn)
   begin
      if (!rstn)
      begin
         state_reg <= SB_ST_ULPS;
         wake_reg  <= 8'h00;
      end
      else
      begin
         state_reg <= state_next;
         if (state_reg == SB_ST_ULPS)
            wake_reg <= 8'(`SB_WAKE_CYC);
         else if (wake_reg != 8'h00)
            wake_reg <= wake_reg - 8'h01;
      end
   end
   assign lp_code     = (state_reg == SB_ST_ULPS) ? `SB_LP00 :
                        (state_reg == SB_ST_EXIT) ? `SB_LP10 : `SB_LP11;
   assign lane        = '{clk_lp: lp_code,
                          dat_lp: lp_code,
                          hs:     (state_reg == SB_ST_HS) || (state_reg == SB_ST_EOFP),
                          oe:     rstn};
   assign link_idle   = (state_reg == SB_ST_ULPS);
   a_ulps_lp00: assert property (@(posedge clk_link) disable iff (!rstn)
      (state_reg == SB_ST_ULPS) |-> (lane.dat_lp == 2'h0 && !lane.hs))
      else $error("link not LP-00 in ULPS");
   a_exit_to_stop: assert property (@(posedge clk_link) disable iff (!rstn)
      (state_reg == SB_ST_EXIT) |-> ##[1:250] (state_reg != SB_ST_EXIT))
      else $error("wakeup exit too long");
   a_eofp_then_ulps: assert property (@(posedge clk_link) disable iff (!rstn)
      (state_reg == SB_ST_EOFP) |=> (state_reg == SB_ST_ULPS))
      else $error("EOF packet not followed by ULPS");
   a_frame_finish: assert property (@(posedge clk_link) disable iff (!rstn)
      (state_reg == SB_ST_HS && frame_mode && !frame_end) |=> (state_reg != SB_ST_ULPS))
      else $error("frame cut short in end-of-frame mode");
endmodule : sbctl_link

// *** design/sbctl_top.sv ***
// Standby and output link state control, system clock side
// Operation
// - Standby pin high forces hard standby
// - Register write enters soft standby
// - Parallel outputs high-Z in reset, standby
// - Standby drives link lanes LP-00
// - Hard standby gates clock and pipeline
// - Hard standby completes within entry window
// - Status bit tracks soft standby
// - Soft standby completes within window
// - Link ULPS to exit to stop
// - Frames as packets, stop between
// - Reset aborts frame, link ULPS
// - Frame-end mode finishes whole frame
// - Line mode finishes packet, sends EOF
// - Pixel data synchronous, clock runs outside standby
`timescale 1ns/1ps
`include "sbctl_defs.svh"
module sbctl_top
   import sbctl_pkg::*;
#(
   parameter int FRAME_CYC = 32'd400000,
   parameter int ENTRY_CYC = `SB_ENTRY_MIN + 8
)
(
   input  wire logic        clk_sys,
   input  wire logic        rstn,
   input  wire logic        ce,
   input  wire logic        clk_link,
   input  wire logic        standby_pin,
   input  wire logic [3:0]  otp_module_id,
   input  wire logic        reg_wr,
   input  wire logic        reg_rd,
   input  wire logic [15:0] reg_addr,
   input  wire logic [15:0] reg_wdata,
   output logic [15:0]      reg_rdata,
   output logic             core_enable,
   output logic             pipe_clk_en,
   output logic             serial_if_en,
   input  wire logic        mipi_mode,
   input  wire logic        pll_ready,
   input  wire sbctl_pix_s  pix_in,
   input  wire logic        frame_start,
   input  wire logic        packet_end,
   input  wire logic        frame_end,
   output sbctl_pix_s       pix_out,
   output logic             pix_clk_out,
   output logic             par_oe,
   output sbctl_lane_s      lane
);
   logic [1:0]  sb_sync_reg;
   logic        req_reg;
   logic        eof_mode_reg;
   logic        soft_done_reg;
   logic        hard_done_reg;
   logic [31:0] cnt_reg;
   logic        srst_reg;
   logic        div_reg;
   logic [1:0]  idle_sync_reg;
   sbctl_pix_s  pix_reg;
   logic        hard_req;
   logic        any_req;
   logic        stream_req;
   logic        link_idle;
   logic        sel_ctrl;
   logic        sel_id;
   logic        sel_stop;
   logic        sel_core;
   logic        entry_done;
   logic        in_standby;
   logic [15:0] ctrl_word;
   logic [15:0] id_word;
   logic [15:0] stop_word;
   logic [15:0] core_word;
   logic        wr_en;
   logic        wr_ctrl;
   logic        wr_stop;
   logic        wr_id;
   logic [31:0] cnt_next;
   logic        soft_next;
   logic        hard_next;

   assign hard_req   = sb_sync_reg[1];
   assign any_req    = hard_req | req_reg;
   // Writes are refused while hard standby holds the serial interface off
   assign wr_en      = ce & reg_wr & ~hard_done_reg;
   assign wr_ctrl    = wr_en & sel_ctrl;
   assign wr_stop    = wr_en & sel_stop;
   assign wr_id      = wr_en & sel_id;
   assign cnt_next   = (any_req && !entry_done) ? cnt_reg + 32'h1 :
                       (any_req ? cnt_reg : 32'h0);
   assign soft_next  = req_reg & (entry_done | soft_done_reg);
   assign hard_next  = hard_req & (entry_done | hard_done_reg);
   assign entry_done = (cnt_reg >= 32'(FRAME_CYC + ENTRY_CYC));
   assign in_standby = hard_done_reg | soft_done_reg;
   assign sel_ctrl   = (reg_addr == `SB_OFS_CTRL);
   assign sel_id     = (reg_addr == `SB_OFS_ID);
   assign sel_stop   = (reg_addr == `SB_OFS_STOPSEL);
   assign sel_core   = (reg_addr == `SB_OFS_CORE);
   assign ctrl_word  = 16'(({15'h0, req_reg} << `SB_BIT_REQ)
                     | ({15'h0, soft_done_reg} << `SB_BIT_STAT));
   assign id_word    = 16'({12'h0, otp_module_id} << `SB_ID_LSB);
   assign stop_word  = 16'({15'h0, eof_mode_reg} << `SB_BIT_EOF);
   assign core_word  = 16'({15'h0, in_standby} << `SB_BIT_CORE);
   assign reg_rdata  = (hard_done_reg || !reg_rd) ? 16'h0000 :
                       sel_ctrl ? ctrl_word :
                       sel_id   ? id_word   :
                       sel_stop ? stop_word :
                       sel_core ? core_word : 16'h0000;

   // Hard standby shuts the serial interface off, soft standby keeps it alive
   assign serial_if_en = ~hard_done_reg;
   assign core_enable  = ~in_standby;
   assign pipe_clk_en  = ~in_standby & ce;
   assign par_oe       = rstn & ~in_standby & ~mipi_mode & ~srst_reg;
   assign pix_out      = pix_reg;
   assign pix_clk_out  = div_reg;

   always_ff @(posedge clk_sys or negedge rstn)
   begin
      if (!rstn)
         sb_sync_reg <= 2'h0;
      else if (ce)
         sb_sync_reg <= {sb_sync_reg[0], standby_pin};
   end

   // Registered before it crosses, so the link side never sees a decode glitch
   always_ff @(posedge clk_sys or negedge rstn)
   begin
      if (!rstn)
         stream_req <= 1'b0;
      else if (ce)
         stream_req <= ~any_req & ~srst_reg & mipi_mode;
   end

   always_ff @(posedge clk_sys or negedge rstn)
   begin
      if (!rstn)
         req_reg <= 1'b0;
      else if (wr_ctrl)
         req_reg <= reg_wdata[`SB_BIT_REQ];
   end

   always_ff @(posedge clk_sys or negedge rstn)
   begin
      if (!rstn)
         eof_mode_reg <= 1'b0;
      else if (wr_stop)
         eof_mode_reg <= reg_wdata[`SB_BIT_EOF];
   end

   // Soft reset is held in the register until written back to zero
   always_ff @(posedge clk_sys or negedge rstn)
   begin
      if (!rstn)
         srst_reg <= 1'b0;
      else if (wr_id)
         srst_reg <= reg_wdata[`SB_BIT_SRST];
   end

   // Entry counter runs from the request; done flags follow the request level
   always_ff @(posedge clk_sys or negedge rstn)
   begin
      if (!rstn)
         cnt_reg <= 32'h0;
      else if (ce)
         cnt_reg <= cnt_next;
   end

   always_ff @(posedge clk_sys or negedge rstn)
   begin
      if (!rstn)
      begin
         soft_done_reg <= 1'b0;
         hard_done_reg <= 1'b0;
      end
      else if (ce)
      begin
         soft_done_reg <= soft_next;
         hard_done_reg <= hard_next;
      end
   end

   always_ff @(posedge clk_sys or negedge rstn)
   begin
      if (!rstn)
         div_reg <= 1'b0;
      else if (ce && !in_standby)
         div_reg <= ~div_reg;
   end

   // Pixels move once per pixel clock period
   always_ff @(posedge clk_sys or negedge rstn)
   begin
      if (!rstn)
         pix_reg <= '0;
      else if (ce && !in_standby && div_reg)
         pix_reg <= pix_in;
   end

   always_ff @(posedge clk_sys or negedge rstn)
   begin
      if (!rstn)
         idle_sync_reg <= 2'h0;
      else if (ce)
         idle_sync_reg <= {idle_sync_reg[0], link_idle};
   end

   sbctl_link u_link
   (
      .clk_link    (clk_link),
      .rstn        (rstn),
      .stream_req  (stream_req),
      .pll_ready   (pll_ready),
      .frame_start (frame_start),
      .packet_end  (packet_end),
      .frame_end   (frame_end),
      .eof_mode    (eof_mode_reg),
      .lane        (lane),
      .link_idle   (link_idle)
   );

   // Standby exit and status tracking
   a_hard_exit: assert property (@(posedge clk_sys) disable iff (!rstn)
      (ce && !hard_req && hard_done_reg) |=> !hard_done_reg)
      else $error("hard standby not left after pin low");

   a_soft_status: assert property (@(posedge clk_sys) disable iff (!rstn)
      (ce && !req_reg) |=> !soft_done_reg)
      else $error("soft status stays after request cleared");

   a_stat_readonly: assert property (@(posedge clk_sys) disable iff (!rstn)
      (wr_ctrl && !req_reg) |=> !soft_done_reg)
      else $error("status bit set by a write");

   // Entry timing
   a_entry_min: assert property (@(posedge clk_sys) disable iff (!rstn)
      $rose(soft_done_reg) |-> $past(cnt_reg) >= 32'(FRAME_CYC + `SB_ENTRY_MIN))
      else $error("soft standby entered too early");

   a_soft_entry_max: assert property (@(posedge clk_sys) disable iff (!rstn)
      (ce && req_reg && entry_done) |=> soft_done_reg)
      else $error("soft standby entry late");

   a_entry_max: assert property (@(posedge clk_sys) disable iff (!rstn)
      (ce && hard_req && entry_done) |=> hard_done_reg)
      else $error("hard standby entry late");

   a_cnt_idle: assert property (@(posedge clk_sys) disable iff (!rstn)
      (ce && !any_req) |=> (cnt_reg == 32'h0))
      else $error("entry counter not cleared");

   // Output pins and link while in standby or soft reset
   a_par_hiz: assert property (@(posedge clk_sys) disable iff (!rstn)
      in_standby |-> !par_oe)
      else $error("parallel port driven in standby");

   a_par_srst: assert property (@(posedge clk_sys) disable iff (!rstn)
      srst_reg |-> !par_oe)
      else $error("parallel port driven in soft reset");

   a_standby_lp00: assert property (@(posedge clk_sys) disable iff (!rstn)
      in_standby |-> idle_sync_reg[1])
      else $error("link not in ULPS during standby");

   a_stream_off: assert property (@(posedge clk_sys) disable iff (!rstn)
      in_standby |-> !stream_req)
      else $error("streaming requested in standby");

   a_serial_gated: assert property (@(posedge clk_sys) disable iff (!rstn)
      hard_done_reg |-> (!serial_if_en && !pipe_clk_en && reg_rdata == 16'h0000))
      else $error("serial or pipe alive in hard standby");

   a_wr_refused: assert property (@(posedge clk_sys) disable iff (!rstn)
      (ce && reg_wr && hard_done_reg) |=>
         ($stable(req_reg) && $stable(eof_mode_reg) && $stable(srst_reg)))
      else $error("register written in hard standby");

   a_soft_keeps_if: assert property (@(posedge clk_sys) disable iff (!rstn)
      (soft_done_reg && !hard_req) |-> serial_if_en)
      else $error("serial interface off in soft standby");

   // Register readback
   a_req_readback: assert property (@(posedge clk_sys) disable iff (!rstn)
      (ce && reg_wr && sel_ctrl && !hard_done_reg) |=> (req_reg == $past(reg_wdata[0])))
      else $error("request bit readback wrong");

   a_id_field: assert property (@(posedge clk_sys) disable iff (!rstn)
      (reg_rd && sel_id && !hard_done_reg) |->
         (reg_rdata[`SB_ID_LSB + 3:`SB_ID_LSB] == otp_module_id))
      else $error("module identifier readback wrong");

   a_core_bit: assert property (@(posedge clk_sys) disable iff (!rstn)
      (reg_rd && sel_core && !hard_done_reg) |-> (reg_rdata[`SB_BIT_CORE] == soft_done_reg))
      else $error("core standby bit readback wrong");

   // Pixel port keeps its clock running outside standby and takes one value per period
   a_pclk_runs: assert property (@(posedge clk_sys) disable iff (!rstn)
      (ce && !in_standby) |=> (div_reg != $past(div_reg)))
      else $error("pixel clock stopped");

   a_pix_capture: assert property (@(posedge clk_sys) disable iff (!rstn)
      (ce && !in_standby && div_reg) |=> (pix_reg == $past(pix_in)))
      else $error("pixel value not taken");
endmodule : sbctl_top

// *** verif/sbctl_partner.sv ***
// Far-side frame source model: frame and packet markers on the link clock
`timescale 1ns/1ps
module sbctl_partner
(
   input  wire logic       clk_link,
   input  wire logic       go,
   input  wire logic [1:0] kind,
   output logic            frame_start,
   output logic            packet_end,
   output logic            frame_end
);
   logic go_seen;
   logic fire;
   assign fire = go ^ go_seen;
   initial
   begin
      go_seen = 1'b0;
      frame_start = 1'b0;
      packet_end = 1'b0;
      frame_end = 1'b0;
   end
   // One-cycle markers, launched off the falling link edge
   always @(negedge clk_link)
   begin
      go_seen <= go;
      frame_start <= fire && kind == 2'h0;
      packet_end <= fire && kind == 2'h1;
      frame_end <= fire && kind == 2'h2;
   end
endmodule : sbctl_partner

// *** verif/standby_and_output_link_state_control_test.sv ***
// Self-checking bench for the standby and output link control block
`timescale 1ns/1ps
`include "sbctl_defs.svh"
module standby_and_output_link_state_control_test
   import sbctl_pkg::*;
;
   localparam int FRM = 100;
   localparam int WAKE = `SB_WAKE_CYC * 32 / 5;
   localparam logic [15:0] IDLE00 = 16'h0001;
   logic        clk_sys, clk_link, rstn, stby, wr, rd, pll, mipi, go, core_en, pipe_en;
   logic        ser_en, pclk, par_oe, fs, pe, fe;
   logic [1:0]  kind;
   logic [15:0] addr, wdata, rdata;
   sbctl_pix_s  pix_in, pix_out;
   sbctl_lane_s lane;
   int          errors = 0, n_compared = 0, cyc = 0, t0;

   sbctl_top #(.FRAME_CYC(FRM)) DUT (.clk_sys(clk_sys), .rstn(rstn), .ce(1'b1),
      .clk_link(clk_link), .standby_pin(stby), .otp_module_id(4'ha), .reg_wr(wr), .reg_rd(rd),
      .reg_addr(addr), .reg_wdata(wdata), .reg_rdata(rdata), .core_enable(core_en),
      .pipe_clk_en(pipe_en), .serial_if_en(ser_en), .mipi_mode(mipi), .pll_ready(pll),
      .pix_in(pix_in), .frame_start(fs), .packet_end(pe), .frame_end(fe), .pix_out(pix_out),
      .pix_clk_out(pclk), .par_oe(par_oe), .lane(lane));
   sbctl_partner FAR (.clk_link(clk_link), .go(go), .kind(kind), .frame_start(fs),
      .packet_end(pe), .frame_end(fe));

   // Both clocks run throughout, standby included
   initial
   begin
      clk_sys = 1'b0;
      forever #2.5 clk_sys = ~clk_sys;
   end
   initial
   begin
      clk_link = 1'b0;
      #7.3;
      forever #16 clk_link = ~clk_link;
   end
   always @(posedge clk_sys)
   begin
      cyc <= cyc + 1;
      if (cyc == 60000)
      begin
         errors = errors + 1;
         print_verdict();
      end
   end

   task automatic print_verdict();
      $display("compared %0d mismatches %0d", n_compared, errors);
      if (errors == 0 && n_compared > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask : print_verdict
   task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
      n_compared++;
      if (got !== exp)
      begin
         errors++;
         $display("[FAIL] %s expected %h seen %h", what, exp, got);
      end
   endtask : chk
   task automatic chkw(input string what, input int lo, input int hi, input int got);
      n_compared++;
      if (got < lo || got > hi)
      begin
         errors++;
         $display("[FAIL] %s expected %0d..%0d seen %0d", what, lo, hi, got);
      end
   endtask : chkw
   task automatic wr16(input logic [15:0] a, input logic [15:0] d);
      @(negedge clk_sys);
      addr = a;
      wdata = d;
      wr = 1'b1;
      @(negedge clk_sys);
      wr = 1'b0;
   endtask : wr16
   task automatic rd16(input logic [15:0] a, output logic [15:0] d);
      @(negedge clk_sys);
      addr = a;
      rd = 1'b1;
      @(posedge clk_sys);
      d = rdata;
      @(negedge clk_sys);
      rd = 1'b0;
   endtask : rd16
   task automatic wlp(input logic [1:0] code, input int max, output int n);
      n = 0;
      while (lane.dat_lp !== code && n < max)
      begin
         @(negedge clk_sys);
         n++;
      end
      chkw("lane wait", 0, max - 1, n);
   endtask : wlp
   task automatic pulse(input logic [1:0] k);
      @(negedge clk_sys);
      kind = k;
      go = ~go;
      repeat (20) @(negedge clk_sys);
   endtask : pulse

   initial
   begin
      logic [15:0] v;
      int n;
      rstn = 0; stby = 0; wr = 0; rd = 0; addr = 0; wdata = 0;
      pll = 0; mipi = 1; go = 0; kind = 0; pix_in = '0;
      repeat (6) @(negedge clk_sys);
      rstn = 1;
      #1;
      chk("par_oe", 16'h0, {15'h0, par_oe});
      chk("lane", IDLE00, {10'h0, lane});
      rd16(`SB_OFS_ID, v); chk("id", 16'ha000, v & 16'hf000);
      rd16(16'h0100, v); chk("unmapped", 16'h0, v);
      wr16(`SB_OFS_STOPSEL, 16'h0001); rd16(`SB_OFS_STOPSEL, v); chk("sel", 16'h1, v);
      wr16(`SB_OFS_STOPSEL, 16'h0000);
      $display("test reset done");
      wr16(`SB_OFS_CTRL, 16'h4001); t0 = cyc;
      rd16(`SB_OFS_CTRL, v); chk("ctrl", 16'h0001, v);
      while (v[14] !== 1'b1 && cyc - t0 < 20000) rd16(`SB_OFS_CTRL, v);
      chkw("soft entry", FRM + `SB_ENTRY_MIN, FRM + `SB_ENTRY_MAX + 8, cyc - t0);
      rd16(`SB_OFS_CORE, v); chk("core", 16'h0010, v & 16'h0010);
      chk("core_en", 16'h0, {15'h0, core_en});
      chk("ser_en", 16'h1, {15'h0, ser_en});
      chk("lane", IDLE00, {10'h0, lane});
      while (cyc - t0 < FRM + `SB_STBY_MIN + 2) @(negedge clk_sys);
      wr16(`SB_OFS_CTRL, 16'h0000);
      rd16(`SB_OFS_CTRL, v); chk("ctrl", 16'h0, v);
      $display("test soft standby done");
      pll = 1;
      wlp(`SB_LP10, 100, n);
      wlp(`SB_LP11, 1400, n);
      chkw("wake", WAKE - 8, WAKE + 8, n);
      pulse(0); chk("hs", 16'h1, {15'h0, lane.hs});
      wr16(`SB_OFS_CTRL, 16'h0001);
      repeat (40) @(negedge clk_sys);
      chk("hs", 16'h1, {15'h0, lane.hs});
      pulse(1); chk("lane", IDLE00, {10'h0, lane});
      wr16(`SB_OFS_CTRL, 16'h0000);
      wlp(`SB_LP11, 1500, n);
      wr16(`SB_OFS_STOPSEL, 16'h0001);
      pulse(0); wr16(`SB_OFS_CTRL, 16'h0001); pulse(1);
      chk("frame kept", 16'h1, {15'h0, {10'h0, lane} !== IDLE00});
      pulse(2); chk("lane", IDLE00, {10'h0, lane});
      wr16(`SB_OFS_CTRL, 16'h0000); wr16(`SB_OFS_STOPSEL, 16'h0000);
      wlp(`SB_LP11, 1500, n);
      $display("test link done");
      pulse(0);
      rstn = 0;
      #1;
      chk("lane oe", 16'h0, {15'h0, lane.oe});
      repeat (16) @(negedge clk_sys);
      rstn = 1;
      #1;
      chk("lane", IDLE00, {10'h0, lane});
      wlp(`SB_LP11, 1500, n);
      $display("test reset abort done");
      @(negedge clk_sys);
      stby = 1; t0 = cyc;
      while (pipe_en !== 1'b0 && cyc - t0 < 20000) @(negedge clk_sys);
      chkw("hard entry", FRM + `SB_ENTRY_MIN, FRM + `SB_ENTRY_MAX + 4, cyc - t0);
      chk("core_en", 16'h0, {15'h0, core_en});
      chk("ser_en", 16'h0, {15'h0, ser_en});
      chk("lane", IDLE00, {10'h0, lane});
      rd16(`SB_OFS_ID, v); chk("gated rd", 16'h0, v);
      wr16(`SB_OFS_STOPSEL, 16'h0001);
      while (cyc - t0 < FRM + `SB_STBY_MIN + 2) @(negedge clk_sys);
      stby = 0; t0 = cyc;
      while (pipe_en !== 1'b1 && cyc - t0 < 100) @(negedge clk_sys);
      chk("pipe_en", 16'h1, {15'h0, pipe_en});
      rd16(`SB_OFS_STOPSEL, v); chk("refused wr", 16'h0, v);
      $display("test hard standby done");
      mipi = 0;
      pix_in = '{data: 8'ha5, lv: 1'b1, fv: 1'b1};
      repeat (10) @(negedge clk_sys);
      chk("par_oe", 16'h1, {15'h0, par_oe});
      chk("pix", {6'h0, pix_in}, {6'h0, pix_out});
      n = 0;
      v[0] = pclk;
      repeat (8)
      begin
         @(negedge clk_sys);
         if (pclk !== v[0]) n++;
         v[0] = pclk;
      end
      chkw("pclk edges", 8, 8, n);
      wr16(`SB_OFS_ID, 16'h0001); chk("srst oe", 16'h0, {15'h0, par_oe});
      wr16(`SB_OFS_ID, 16'h0000); chk("srst off", 16'h1, {15'h0, par_oe});
      $display("test parallel done");
      print_verdict();
   end
endmodule : standby_and_output_link_state_control_test
